// >>> logic/ota_notify_pkg.sv
// Package of constants and types for the image notify handler
package ota_notify_pkg;
    // ========================================
    // Addressing
    localparam logic [7:0] OTA_ENDPOINT = 8'hE8;
    localparam logic [15:0] OTA_CLUSTER = 16'h0019;
    localparam logic [15:0] OTA_PROFILE = 16'hC105;
    // ========================================
    // Frame control and command codes
    localparam logic [7:0] FC_UNICAST = 8'h09;
    localparam logic [7:0] FC_BROADCAST = 8'h19;
    localparam logic [7:0] FC_CLIENT_CMD = 8'h01;
    localparam logic [7:0] CMD_IMAGE_NOTIFY = 8'h00;
    localparam logic [7:0] CMD_QUERY_NEXT = 8'h01;
    localparam logic [7:0] CMD_DEFAULT_RSP = 8'h0B;
    localparam logic [7:0] STATUS_MALFORMED = 8'h80;
    localparam logic [7:0] STATUS_NO_MATCH = 8'h98;
    // ========================================
    // Payload layout
    localparam logic [7:0] OFS_FC = 8'h00;
    localparam logic [7:0] OFS_SEQ = 8'h01;
    localparam logic [7:0] OFS_CMD = 8'h02;
    localparam logic [7:0] OFS_PTYPE = 8'h03;
    localparam logic [7:0] OFS_JITTER = 8'h04;
    localparam logic [7:0] OFS_MFR = 8'h05;
    localparam logic [7:0] OFS_ITYPE = 8'h07;
    localparam logic [7:0] OFS_FVER = 8'h09;
    localparam logic [7:0] PTYPE_MAX = 8'h03;
    localparam logic [7:0] JITTER_FULL = 8'h64;
    localparam logic [7:0] QUERY_LEN = 8'h0C;
    localparam logic [7:0] DEFRSP_LEN = 8'h05;
    localparam logic [15:0] ITYPE_FIRMWARE = 16'h0000;
    localparam logic [15:0] ITYPE_FILESYS = 16'h0100;
    // ========================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int RSP_TIMEOUT_US = 1000;
    localparam int RSP_TIMEOUT_CYC = RSP_TIMEOUT_US * CLK_MHZ;
    localparam int RETRY_MAX = 3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RECV = 3'b001,
        ST_DECIDE = 3'b010,
        ST_SEND = 3'b011,
        ST_WAIT = 3'b100
    } state_t;

    typedef struct packed {
        logic [7:0] src_ep;
        logic [7:0] dst_ep;
        logic [15:0] cluster;
        logic [15:0] profile;
        logic broadcast;
    } addr_t;

    typedef struct packed {
        logic [15:0] mfr;
        logic [15:0] itype;
        logic [31:0] fver;
    } image_id_t;
endpackage

// >>> logic/ota_image_notify_handler.sv
// Image notify interpreter and client retry sequencer
// ========================================
// Summary of operation
// - Only frames on endpoint 0xE8, cluster 0x0019, profile 0xC105 are taken and sent.
// - Byte order of every multi-byte field is little-endian, both in and out.
// - Byte two must be command 0x00; byte one is a free sequence number.
// - The payload type at offset three selects which optional fields follow, up to 3.
// - Manufacturer code sits at 5, image type at 7, file version at 9.
// - A broadcast with jitter below 100 is answered only if a random draw is below it.
// - A valid unicast that matches gets a next-image query, an invalid one a default response.
// - A broadcast is answered only when its present fields match this client.
// - A unicast whose optional fields mismatch gets a default response.
// - An unanswered request is resent a limited number of times, then the upgrade aborts.
// - The client drives the rest of the upgrade; the server keeps no client state.
// - Image type 0x0000 is firmware and 0x0100 is file system.
// - The file version top byte is compatibility, the lower three the firmware version.
`timescale 1ns/1ps
module ota_image_notify_handler
    import ota_notify_pkg::*;
#(
    parameter int TIMEOUT_CYC = RSP_TIMEOUT_CYC,
    parameter int RETRIES = RETRY_MAX
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rx_start,
    input wire addr_t rx_addr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire image_id_t own_id,
    input wire logic [7:0] own_seq,
    input wire logic rsp_seen,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    output addr_t tx_addr,
    input wire logic tx_ready,
    output logic upgrade_active,
    output logic upgrade_abort,
    output logic is_filesys,
    output logic [7:0] compat_num
);
    // Retry count must fit the four-bit try counter
    if (TIMEOUT_CYC < 1 || RETRIES < 1 || RETRIES > 15) begin : g_bad_param
        $error("ota_image_notify_handler: bad parameter");
    end

    typedef struct packed {
        state_t st;
        logic [7:0] idx;
        logic [7:0] fc;
        logic [7:0] seq;
        logic [7:0] cmd;
        logic [7:0] ptype;
        logic [7:0] jitter;
        image_id_t img;
        logic bcast;
        logic addr_ok;
        logic send_query;
        logic [7:0] tx_idx;
        logic [31:0] timer;
        logic [3:0] tries;
        logic [15:0] lfsr;
        logic tx_valid;
        logic [7:0] tx_data;
        logic tx_last;
        logic active;
        logic abort;
        logic fs;
        logic [7:0] compat;
    } state_s_t;

    state_s_t q, d;

    // Bytes needed for a given payload type
    function automatic logic [7:0] need_len(input logic [7:0] pt);
        case (pt)
            8'h00: need_len = OFS_MFR;
            8'h01: need_len = OFS_ITYPE;
            8'h02: need_len = OFS_FVER;
            default: need_len = 8'h0D;
        endcase
    endfunction

    // Outgoing byte at position i
    function automatic logic [7:0] tx_byte(input state_s_t s, input image_id_t id,
                                           input logic [7:0] sq, input logic [7:0] i);
        tx_byte = 8'h00;
        if (s.send_query) begin
            case (i)
                8'h00: tx_byte = FC_CLIENT_CMD;
                8'h01: tx_byte = sq;
                8'h02: tx_byte = CMD_QUERY_NEXT;
                8'h03: tx_byte = 8'h00;
                8'h04: tx_byte = id.mfr[7:0];
                8'h05: tx_byte = id.mfr[15:8];
                8'h06: tx_byte = id.itype[7:0];
                8'h07: tx_byte = id.itype[15:8];
                8'h08: tx_byte = id.fver[7:0];
                8'h09: tx_byte = id.fver[15:8];
                8'h0A: tx_byte = id.fver[23:16];
                8'h0B: tx_byte = id.fver[31:24];
                default: tx_byte = 8'h00;
            endcase
        end else begin
            case (i)
                8'h00: tx_byte = FC_UNICAST;
                8'h01: tx_byte = s.seq;
                8'h02: tx_byte = CMD_DEFAULT_RSP;
                8'h03: tx_byte = s.cmd;
                8'h04: tx_byte = (s.ptype > PTYPE_MAX || s.idx < need_len(s.ptype)
                                  || s.cmd != CMD_IMAGE_NOTIFY) ? STATUS_MALFORMED
                                                                : STATUS_NO_MATCH;
                default: tx_byte = 8'h00;
            endcase
        end
    endfunction

    logic match;
    logic valid_fmt;
    logic [7:0] tx_len;

    always_comb begin
        // Only fields that are present are compared
        match = 1'b1;
        if (q.ptype >= 8'h01 && q.img.mfr != own_id.mfr) match = 1'b0;
        if (q.ptype >= 8'h02 && q.img.itype != own_id.itype) match = 1'b0;
        if (q.ptype >= 8'h03 && q.img.fver != own_id.fver) match = 1'b0;
        valid_fmt = q.addr_ok && q.cmd == CMD_IMAGE_NOTIFY && q.ptype <= PTYPE_MAX
                    && q.idx >= need_len(q.ptype);
        tx_len = q.send_query ? QUERY_LEN : DEFRSP_LEN;
    end

    // ========================================
    // Next state
    always_comb begin
        d = q;
        d.abort = 1'b0;
        d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
        case (q.st)
            ST_IDLE, ST_WAIT: begin
                if (q.st == ST_WAIT) begin
                    if (rsp_seen) begin
                        // Later commands belong to the transfer logic beyond this block
                        d.st = ST_IDLE;
                    end else if (q.timer == 32'h0000_0000) begin
                        if (q.tries == 4'(RETRIES)) begin
                            d.st = ST_IDLE;
                            d.active = 1'b0;
                            d.abort = 1'b1;
                        end else begin
                            d.st = ST_SEND;
                            d.tries = q.tries + 4'h1;
                            d.tx_idx = 8'h00;
                        end
                    end else begin
                        d.timer = q.timer - 32'h0000_0001;
                    end
                end
                // A new frame preempts any wait, a later notify restarts the query
                if (rx_start) begin
                    d.st = ST_RECV;
                    d.idx = 8'h00;
                    d.ptype = 8'hFF;
                    d.cmd = 8'hFF;
                    d.bcast = rx_addr.broadcast;
                    d.addr_ok = rx_addr.src_ep == OTA_ENDPOINT
                                && rx_addr.dst_ep == OTA_ENDPOINT
                                && rx_addr.cluster == OTA_CLUSTER
                                && rx_addr.profile == OTA_PROFILE;
                end
            end
            ST_RECV: begin
                if (rx_valid) begin
                    d.idx = (q.idx == 8'hFF) ? q.idx : q.idx + 8'h01;
                    case (q.idx)
                        OFS_FC: d.fc = rx_data;
                        OFS_SEQ: d.seq = rx_data;
                        OFS_CMD: d.cmd = rx_data;
                        OFS_PTYPE: d.ptype = rx_data;
                        OFS_JITTER: d.jitter = rx_data;
                        OFS_MFR: d.img.mfr[7:0] = rx_data;
                        8'h06: d.img.mfr[15:8] = rx_data;
                        OFS_ITYPE: d.img.itype[7:0] = rx_data;
                        8'h08: d.img.itype[15:8] = rx_data;
                        OFS_FVER: d.img.fver[7:0] = rx_data;
                        8'h0A: d.img.fver[15:8] = rx_data;
                        8'h0B: d.img.fver[23:16] = rx_data;
                        8'h0C: d.img.fver[31:24] = rx_data;
                        default: ;
                    endcase
                    if (rx_last) d.st = ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                d.st = ST_IDLE;
                d.tx_idx = 8'h00;
                d.tries = 4'h0;
                if (!q.addr_ok) begin
                    d.st = ST_IDLE;
                end else if (q.bcast) begin
                    // Silence on any broadcast fault, no default response
                    if (valid_fmt && match && (q.jitter >= JITTER_FULL
                            || {1'b0, q.lfsr[6:0]} < q.jitter)) begin
                        d.st = ST_SEND;
                        d.send_query = 1'b1;
                    end
                end else if (q.cmd == CMD_IMAGE_NOTIFY || !valid_fmt) begin
                    d.st = ST_SEND;
                    d.send_query = valid_fmt && match;
                end
                if (d.st == ST_SEND && d.send_query) begin
                    d.active = 1'b1;
                    d.fs = q.ptype >= 8'h02 && q.img.itype == ITYPE_FILESYS;
                    d.compat = own_id.fver[31:24];
                end
            end
            ST_SEND: begin
                if (!q.tx_valid || tx_ready) begin
                    if (q.tx_valid && q.tx_last) begin
                        d.tx_valid = 1'b0;
                        d.tx_last = 1'b0;
                        d.timer = 32'(TIMEOUT_CYC - 1);
                        d.st = q.send_query ? ST_WAIT : ST_IDLE;
                    end else begin
                        d.tx_valid = 1'b1;
                        d.tx_data = tx_byte(q, own_id, own_seq, q.tx_idx);
                        d.tx_last = q.tx_idx == tx_len - 8'h01;
                        d.tx_idx = q.tx_idx + 8'h01;
                    end
                end
            end
            default: d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.lfsr <= 16'hACE1;
        end else begin
            q <= d;
        end
    end

    // ========================================
    // Outputs
    assign tx_valid = q.tx_valid;
    assign tx_data = q.tx_data;
    assign tx_last = q.tx_last;
    assign tx_addr = '{src_ep: OTA_ENDPOINT, dst_ep: OTA_ENDPOINT,
                       cluster: OTA_CLUSTER, profile: OTA_PROFILE, broadcast: 1'b0};
    assign upgrade_active = q.active;
    assign upgrade_abort = q.abort;
    assign is_filesys = q.fs;
    assign compat_num = q.compat;
endmodule

// >>> tb/ota_asserts.sv
// Port assertions for the image notify handler
`timescale 1ns/1ps
module ota_asserts
    import ota_notify_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic rx_start,
    input wire addr_t rx_addr,
    input wire logic rx_valid,
    input wire logic rx_last,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire addr_t tx_addr,
    input wire logic tx_ready,
    input wire logic upgrade_active,
    input wire logic upgrade_abort
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // ========================================
    // Marks a foreign-profile frame started while no upgrade is active, until the next frame start
    logic foreign_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            foreign_q <= 1'b0;
        end else if (rx_start) begin
            foreign_q <= !upgrade_active && rx_addr.profile != OTA_PROFILE;
        end
    end
    // ========================================
    // Reply stream
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
        && $stable(tx_last)) else $error("reply byte changed while stalled");
    a_tx_addr: assert property (tx_valid |-> tx_addr.src_ep == OTA_ENDPOINT
        && tx_addr.cluster == OTA_CLUSTER && tx_addr.profile == OTA_PROFILE)
        else $error("reply addressing wrong");
    a_first_byte: assert property ($rose(tx_valid) |-> tx_data == FC_CLIENT_CMD
        || tx_data == FC_UNICAST) else $error("reply opens with wrong frame control");
    a_reply_time: assert property ($rose(tx_valid) |-> upgrade_active
        || $past(rx_valid && rx_last, 3)) else $error("reply not three cycles after frame");
    // Watched from the last byte, since a reply could only start after it
    a_silent_foreign: assert property (foreign_q && rx_valid && rx_last
        |=> !tx_valid [*8])
        else $error("reply to foreign profile");
    // ========================================
    // Retry and abort
    a_abort_pulse: assert property (upgrade_abort |=> !upgrade_abort)
        else $error("abort longer than one cycle");
    a_abort_source: assert property ($fell(upgrade_active) |-> upgrade_abort
        || $past(upgrade_abort)) else $error("upgrade dropped without abort");
    a_abort_active: assert property ($rose(upgrade_abort) |-> upgrade_active
        || $past(upgrade_active)) else $error("abort with no upgrade running");
endmodule
bind ota_image_notify_handler ota_asserts chk_i (.clk, .nrst, .rx_start, .rx_addr, .rx_valid,
    .rx_last, .tx_valid, .tx_data, .tx_last, .tx_addr, .tx_ready, .upgrade_active, .upgrade_abort);

// >>> tb/ota_server_model.sv
// Upgrade server model: sends notify frames and takes client replies
`timescale 1ns/1ps
module ota_server_model
    import ota_notify_pkg::*;
(
    input wire logic clk,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic rx_start,
    output addr_t rx_addr,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic rsp_seen,
    output logic tx_ready
);
    logic [7:0] got[$];
    initial begin
        {rx_start, rx_valid, rx_last, rsp_seen, tx_ready} = '0;
        rx_addr = '0;
        rx_data = 8'hA5;
    end
    // ========================================
    // Slow mode stalls every other cycle
    always @(posedge clk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        #1;
        tx_ready = slow ? !tx_ready : 1'b1;
    end
    // The server only opens with a notify, then just answers; it keeps no client state
    task automatic notify(input logic bc, input logic [7:0] sq,
        input logic [7:0] pt, input logic [7:0] jit, input image_id_t id, input int n,
        input logic [15:0] prof);
        logic [7:0] b[13];
        b = '{bc ? FC_BROADCAST : FC_UNICAST, sq, CMD_IMAGE_NOTIFY, pt,
            bc ? jit : JITTER_FULL, id.mfr[7:0], id.mfr[15:8], id.itype[7:0],
            id.itype[15:8], id.fver[7:0], id.fver[15:8], id.fver[23:16], id.fver[31:24]};
        @(posedge clk);
        #1;
        rx_start = 1;
        rx_addr = '{OTA_ENDPOINT, OTA_ENDPOINT, OTA_CLUSTER, prof, bc};
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            rx_start = 0;
            rx_addr = ~rx_addr;
            rx_valid = 1;
            rx_data = b[i];
            rx_last = (i == n - 1);
        end
        @(posedge clk);
        #1;
        rx_valid = 0;
        rx_last = 0;
        rx_data = ~rx_data;
    endtask
    task automatic ack();
        @(posedge clk);
        #1;
        rsp_seen = 1;
        @(posedge clk);
        #1;
        rsp_seen = 0;
    endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the image notify handler
`timescale 1ns/1ps
module tb_top
    import ota_notify_pkg::*;
;
    typedef logic [7:0] bq_t[$];
    logic clk = 0;
    logic nrst = 0;
    logic slow = 0;
    logic [31:0] rs = 32'h0000002E;
    logic [7:0] own_seq = 8'h00;
    int mismatches = 0;
    int checks = 0;
    int aborts = 0;
    int len[5] = '{5, 7, 9, 13, 13};
    // Client identity values are arbitrary apart from the file system image type and compatibility 0x02, which are checked
    image_id_t own = '{16'h5A3C, ITYPE_FILESYS, 32'h02123456};
    addr_t rx_addr, tx_addr;
    logic [7:0] rx_data, tx_data, compat_num;
    logic rx_start, rx_valid, rx_last, rsp_seen, tx_valid, tx_last, tx_ready;
    logic upgrade_active, upgrade_abort, is_filesys;
    // Short timeout keeps the retry test brief
    ota_image_notify_handler #(.TIMEOUT_CYC(20), .RETRIES(3)) DUT (.clk, .nrst, .rx_start,
        .rx_addr, .rx_valid, .rx_data, .rx_last, .own_id(own), .own_seq, .rsp_seen, .tx_valid,
        .tx_data, .tx_last, .tx_addr, .tx_ready, .upgrade_active, .upgrade_abort, .is_filesys,
        .compat_num);
    ota_server_model srv (.clk, .slow, .tx_valid, .tx_data, .rx_start, .rx_addr, .rx_valid,
        .rx_data, .rx_last, .rsp_seen, .tx_ready);
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (upgrade_abort === 1'b1) aborts++;
    function automatic logic [7:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction
    function automatic bq_t q_exp();
        return '{FC_CLIENT_CMD, own_seq, CMD_QUERY_NEXT, 8'h00, own.mfr[7:0], own.mfr[15:8],
            own.itype[7:0], own.itype[15:8], own.fver[7:0], own.fver[15:8], own.fver[23:16],
            own.fver[31:24]};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, s, e);
        end
    endtask
    // ========================================
    // One notify; st 0 silent, 1 query, 2 unanswered query, else default response status
    task automatic run(input string nm, input logic bc, input logic [7:0] pt,
        input logic [7:0] jit, input image_id_t id, input int n, input logic [15:0] prof,
        input logic [7:0] st);
        int k;
        logic [7:0] sq;
        bq_t e;
        sq = rnd();
        slow = rs[9];
        case (st)
            8'h00: e = {};
            8'h01: e = q_exp();
            8'h02: e = {q_exp(), q_exp(), q_exp(), q_exp()};
            default: e = '{FC_UNICAST, sq, CMD_DEFAULT_RSP, CMD_IMAGE_NOTIFY, st};
        endcase
        k = 0;
        srv.notify(bc, sq, pt, jit, id, n, prof);
        while (srv.got.size() < e.size() && k < 400) begin
            @(posedge clk);
            k++;
        end
        if (st != 8'h02) srv.ack();
        repeat (st == 8'h02 ? 40 : 10) @(posedge clk);
        chk(srv.got.size(), e.size());
        foreach (e[i]) chk(srv.got[i], e[i]);
        srv.got.delete();
        $display("test %s done", nm);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        #1;
        nrst = 1;
        own_seq = rnd();
        for (int p = 0; p < 4; p++) begin
            run("unicast match", 0, p[7:0], 8'h00, own, len[p], OTA_PROFILE, 8'h01);
        end
        chk(is_filesys, 1);
        chk(compat_num, 8'h02);
        for (int k = 0; k < 3; k++) begin
            run("unicast mismatch", 0, 8'(k + 1), 8'h00, own ^ (64'h1 << (48 - 16 * k)),
                len[k + 1], OTA_PROFILE, STATUS_NO_MATCH);
        end
        run("bad payload type", 0, 8'h04, 8'h00, own, 13, OTA_PROFILE, STATUS_MALFORMED);
        run("short frame", 0, 8'h03, 8'h00, own, 10, OTA_PROFILE, STATUS_MALFORMED);
        run("bcast mismatch", 1, 8'h02, 8'h64, own ^ (64'h1 << 32), 9, OTA_PROFILE,
            8'h00);
        run("bcast jitter zero", 1, 8'h03, 8'h00, own, 13, OTA_PROFILE, 8'h00);
        run("bcast match", 1, 8'h03, 8'h64, own, 13, OTA_PROFILE, 8'h01);
        run("no answer", 0, 8'h03, 8'h00, own, 13, OTA_PROFILE, 8'h02);
        chk(aborts, 1);
        chk(upgrade_active, 0);
        run("foreign profile", 0, 8'h03, 8'h00, own, 13, 16'h0104, 8'h00);
        summarize();
    end
endmodule
